// file: design/onoff_ctrl.sv
/*
 * Top-level on/off state machine of a multi-output power device.
 * Assumes the wake input is already debounced by the caller, faults are
 * synchronous levels, and the sequencer reports completion pulses or levels.
 */
// Operation
// - Unmasked pending interrupt drives irq low
// - Hold reset below threshold, then shutdown
// - Shutdown: bias and bus off, flags kept
// - Three wake conditions leave shutdown
// - Power up only with no fault inputs active
// - Power-up done enters resource-on, bias on
// - Cold reset, power off, manual reset power down
// - Standby command powers down into standby
// - Standby: sequenced outputs off, forced stay on
// - Standby bias low power when setting set
// - After power-down: standby or bias off
// - Button edge, exit command, manual reset leave standby
// - Logic mode high wake input powers down
// - Manual reset in resource-on: power-down, bias off, shutdown
// - Undervoltage at wake returns to shutdown
// - Mode field: button, slide, logic codes
// - Thermal shutdown sets thermal event flag
`timescale 1ns/10ps
module onoff_ctrl #(
    parameter int CH = onoff_pkg::CHANNELS
) (
    input  wire logic                         ref_clk,
    input  wire logic                         arst_n,
    input  wire logic                         por_n,
    input  wire logic                         wake_request_n,
    input  wire logic                         wake_fall,
    input  wire logic [1:0]                   wake_input_mode,
    input  wire logic                         manual_reset,
    input  wire logic [2:0]                   soft_command_field,
    input  wire logic                         soft_command_write,
    input  wire onoff_pkg::fault_type         faults,
    input  wire onoff_pkg::seq_status_type    seq_status,
    input  wire logic                         bias_low_power,
    input  wire logic [3*CH-1:0]              channel_enable_field,
    input  wire logic                         irq_pending,
    input  wire logic                         irq_unmasked,
    input  wire logic                         flags_clear,
    output logic                              irq_out_n,
    output logic                              irq_out_oe_n,
    output logic                              bias_enable,
    output logic                              bias_lp,
    output logic                              bus_enable,
    output logic                              seq_power_up,
    output logic                              seq_power_down,
    output logic                              seq_imm_shdn,
    output logic                              seq_bias_off,
    output logic [CH-1:0]                     channel_on,
    output onoff_pkg::fault_type              event_record_flags,
    output onoff_pkg::state_type              state
);

    ////////////////////////////////////////////////////////////////////////
    onoff_pkg::state_type state_reg, state_next;
    logic                 to_standby_reg, to_standby_next;
    logic                 wake_flag_reg;
    onoff_pkg::fault_type flags_reg;
    logic [CH-1:0]        chan_reg, chan_next;
    logic                 irq_reg;

    // One-shot command decode: only a write strobe counts
    wire       cmd_cold    = soft_command_write && soft_command_field == onoff_pkg::CMD_COLD_RESET;
    wire       cmd_off     = soft_command_write && soft_command_field == onoff_pkg::CMD_POWER_OFF;
    wire       cmd_stby    = soft_command_write && soft_command_field == onoff_pkg::CMD_STANDBY;
    wire       cmd_exit    = soft_command_write && soft_command_field == onoff_pkg::CMD_EXIT_STBY;
    wire       logic_mode  = wake_input_mode == onoff_pkg::MODE_LOGIC;
    wire       edge_mode   = wake_input_mode == onoff_pkg::MODE_BUTTON ||
                             wake_input_mode == onoff_pkg::MODE_SLIDE;
    wire       button_mode = wake_input_mode == onoff_pkg::MODE_BUTTON;
    // Wake from shutdown by edge, logic low or stored cold-reset flag
    wire       wake_shdn   = (edge_mode && wake_fall) || (logic_mode && !wake_request_n)
                             || wake_flag_reg;
    wire       any_fault   = faults.undervoltage | faults.overvoltage | faults.thermal;
    wire       logic_off   = logic_mode && wake_request_n;
    wire       pd_request  = cmd_cold || cmd_off || manual_reset || logic_off;
    wire       stby_leave  = (button_mode && wake_fall) || cmd_exit || manual_reset;

    // Forced-on channels survive standby
    function automatic logic forced(input logic [2:0] code);
        forced = code == onoff_pkg::EN_FORCE_A || code == onoff_pkg::EN_FORCE_B;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        state_next      = state_reg;
        to_standby_next = to_standby_reg;
        chan_next       = chan_reg;
        case (state_reg)
            onoff_pkg::ST_RESET: begin
                if (por_n) begin
                    state_next = onoff_pkg::ST_SHUTDOWN;
                end
            end
            onoff_pkg::ST_SHUTDOWN: begin
                if (wake_shdn) begin
                    state_next = onoff_pkg::ST_WAKE;
                end
            end
            onoff_pkg::ST_WAKE: begin
                // Any fault, undervoltage included, drops back
                if (any_fault) begin
                    state_next = onoff_pkg::ST_SHUTDOWN;
                end else begin
                    state_next = onoff_pkg::ST_POWER_UP;
                end
            end
            onoff_pkg::ST_POWER_UP: begin
                if (seq_status.up_done) begin
                    state_next = onoff_pkg::ST_RES_ON;
                    chan_next  = '1;
                end
            end
            onoff_pkg::ST_RES_ON: begin
                if (cmd_stby) begin
                    state_next      = onoff_pkg::ST_POWER_DN;
                    to_standby_next = 1'b1;
                end else if (pd_request) begin
                    state_next      = onoff_pkg::ST_POWER_DN;
                    to_standby_next = 1'b0;
                end
            end
            onoff_pkg::ST_POWER_DN: begin
                if (seq_status.down_done) begin
                    if (to_standby_reg) begin
                        state_next = onoff_pkg::ST_STANDBY;
                        for (int i = 0; i < CH; i++) begin
                            chan_next[i] = forced(channel_enable_field[3*i +: 3]);
                        end
                    end else begin
                        state_next = onoff_pkg::ST_BIAS_OFF;
                        chan_next  = '0;
                    end
                end
            end
            onoff_pkg::ST_STANDBY: begin
                if (stby_leave) begin
                    state_next = onoff_pkg::ST_WAKE;
                end
            end
            onoff_pkg::ST_IMM_SHDN: begin
                chan_next = '0;
                if (seq_status.shdn_done) begin
                    state_next = onoff_pkg::ST_BIAS_OFF;
                end
            end
            onoff_pkg::ST_BIAS_OFF: begin
                if (seq_status.bias_off_done) begin
                    state_next = onoff_pkg::ST_SHUTDOWN;
                end
            end
            default: begin
                state_next = onoff_pkg::ST_RESET;
            end
        endcase
        // Lockouts override the state case in power-up, resource-on, power-down and standby; only por_n low wins over them
        if (any_fault && state_reg != onoff_pkg::ST_RESET && state_reg != onoff_pkg::ST_SHUTDOWN
            && state_reg != onoff_pkg::ST_WAKE && state_reg != onoff_pkg::ST_IMM_SHDN
            && state_reg != onoff_pkg::ST_BIAS_OFF) begin
            state_next = onoff_pkg::ST_IMM_SHDN;
            chan_next  = '0;
        end
        if (!por_n) begin
            state_next = onoff_pkg::ST_RESET;
            chan_next  = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State and channel registers
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg      <= onoff_pkg::ST_RESET;
            to_standby_reg <= 1'b0;
            chan_reg       <= '0;
        end else begin
            state_reg      <= state_next;
            to_standby_reg <= to_standby_next;
            chan_reg       <= chan_next;
        end
    end

    // Cold reset remembers a wake so shutdown powers straight back up
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wake_flag_reg <= 1'b0;
        end else if (state_reg == onoff_pkg::ST_RES_ON && cmd_cold) begin
            wake_flag_reg <= 1'b1;
        end else if (state_reg == onoff_pkg::ST_WAKE) begin
            wake_flag_reg <= 1'b0;
        end
    end

    // Event flags: set wins over clear; kept through shutdown
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= (flags_clear ? '0 : flags_reg) | faults;
        end
    end

    // Interrupt line, registered
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_pending && irq_unmasked;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output decode; bias and bus off in reset, shutdown and bias-off
    wire bias_on = state_reg != onoff_pkg::ST_RESET && state_reg != onoff_pkg::ST_SHUTDOWN;

    assign bias_enable        = bias_on && state_reg != onoff_pkg::ST_BIAS_OFF;
    assign bus_enable         = bias_enable;
    assign bias_lp            = state_reg == onoff_pkg::ST_STANDBY && bias_low_power;
    assign seq_power_up       = state_reg == onoff_pkg::ST_POWER_UP;
    assign seq_power_down     = state_reg == onoff_pkg::ST_POWER_DN;
    assign seq_imm_shdn       = state_reg == onoff_pkg::ST_IMM_SHDN;
    assign seq_bias_off       = state_reg == onoff_pkg::ST_BIAS_OFF;
    assign channel_on         = chan_reg;
    assign event_record_flags = flags_reg;
    assign state              = state_reg;
    assign irq_out_n          = 1'b0;     // Open drain only pulls low
    assign irq_out_oe_n       = !irq_reg; // Enable low while pulling

endmodule

// file: design/onoff_pkg.sv
/*
 * Constants and types shared by the on/off power state controller.
 * Assumes a single 20 MHz clock domain; no bus, all controls are ports.
 */
package onoff_pkg;

    // Software command codes in the command field
    localparam logic [2:0] CMD_NONE       = 3'h0;
    localparam logic [2:0] CMD_COLD_RESET = 3'h1;
    localparam logic [2:0] CMD_POWER_OFF  = 3'h2;
    localparam logic [2:0] CMD_STANDBY    = 3'h3;
    localparam logic [2:0] CMD_EXIT_STBY  = 3'h4;

    // Wake input modes
    localparam logic [1:0] MODE_BUTTON = 2'h0;
    localparam logic [1:0] MODE_SLIDE  = 2'h1;
    localparam logic [1:0] MODE_LOGIC  = 2'h2;

    // Channel enable codes meaning forced on
    localparam logic [2:0] EN_FORCE_A = 3'h6;
    localparam logic [2:0] EN_FORCE_B = 3'h7;

    localparam int         CHANNELS   = 4;

    // Controller states
    typedef enum logic [3:0] {
        ST_RESET     = 4'h0,
        ST_SHUTDOWN  = 4'h1,
        ST_WAKE      = 4'h2,
        ST_POWER_UP  = 4'h3,
        ST_RES_ON    = 4'h4,
        ST_POWER_DN  = 4'h5,
        ST_STANDBY   = 4'h6,
        ST_IMM_SHDN  = 4'h7,
        ST_BIAS_OFF  = 4'h8
    } state_type;

    // Fault inputs from the monitors
    typedef struct packed {
        logic undervoltage;
        logic overvoltage;
        logic thermal;
    } fault_type;

    // Sequencer handshake back to the controller
    typedef struct packed {
        logic up_done;
        logic down_done;
        logic shdn_done;
        logic bias_off_done;
    } seq_status_type;

endpackage

// file: test/onoff_ctrl_props.sv
/* Port checker for the on/off state controller.
 * Assumes one ref_clk domain and the arst_n reset; attached by bind. */
`timescale 1ns/10ps
module onoff_ctrl_chk (
    input wire logic                     ref_clk,
    input wire logic                     arst_n,
    input wire logic                     por_n,
    input wire logic                     manual_reset,
    input wire logic [2:0]               soft_command_field,
    input wire logic                     soft_command_write,
    input wire onoff_pkg::fault_type     faults,
    input wire onoff_pkg::seq_status_type seq_status,
    input wire logic                     bias_low_power,
    input wire logic                     irq_pending,
    input wire logic                     irq_unmasked,
    input wire logic                     irq_out_oe_n,
    input wire logic                     bias_enable,
    input wire logic                     bus_enable,
    input wire logic                     bias_lp,
    input wire onoff_pkg::fault_type     event_record_flags,
    input wire onoff_pkg::state_type     state
);
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // Supply good and no fault pending
    wire logic ok = por_n && (faults == 3'h0);
    ////////////////////////////////////////////////////////////////////////
    a_irq_pull_low: assert property (
        1'b1 |=> irq_out_oe_n == !($past(irq_pending) && $past(irq_unmasked))) else $error("irq line wrong");
    a_por_hold: assert property (
        !por_n |=> state == onoff_pkg::ST_RESET) else $error("not held in reset");
    a_shdn_bias_off: assert property (
        state == onoff_pkg::ST_SHUTDOWN |-> !bias_enable && !bus_enable) else $error("bias on in shutdown");
    a_wake_fault: assert property (
        state == onoff_pkg::ST_WAKE && por_n && faults != 3'h0 |=> state == onoff_pkg::ST_SHUTDOWN)
        else $error("woke with fault");
    a_powerup_done: assert property (
        state == onoff_pkg::ST_POWER_UP && seq_status.up_done && ok
        |=> state == onoff_pkg::ST_RES_ON && bias_enable && bus_enable) else $error("no resource-on");
    a_cmd_power_down: assert property (
        state == onoff_pkg::ST_RES_ON && ok && (manual_reset || soft_command_write &&
        soft_command_field inside {3'h1, 3'h2}) |=> state == onoff_pkg::ST_POWER_DN) else $error("no power-down");
    a_standby_entry: assert property (
        state == onoff_pkg::ST_RES_ON && ok && soft_command_write && soft_command_field == onoff_pkg::CMD_STANDBY
        |=> state == onoff_pkg::ST_POWER_DN) else $error("standby not started");
    a_standby_lp: assert property (
        state == onoff_pkg::ST_STANDBY |-> bias_lp == bias_low_power && bias_enable) else $error("bias mode wrong");
    a_fault_imm: assert property (
        state == onoff_pkg::ST_RES_ON && por_n && faults != 3'h0 |=> state == onoff_pkg::ST_IMM_SHDN)
        else $error("no immediate shutdown");
    a_thermal_flag: assert property (
        state == onoff_pkg::ST_RES_ON && faults.thermal |=> event_record_flags.thermal) else $error("flag not set");
endmodule
bind onoff_ctrl onoff_ctrl_chk onoff_ctrl_chk_inst (.*);

// file: test/seq_model.sv
/* Stand-in for the power sequencer facing the controller.
 * Assumes request levels from the controller; answers after dly cycles. */
`timescale 1ns/10ps
module seq_model (
    input wire logic                     ref_clk,
    input wire logic                     arst_n,
    input wire logic                     seq_power_up,
    input wire logic                     seq_power_down,
    input wire logic                     seq_imm_shdn,
    input wire logic                     seq_bias_off,
    input wire logic [7:0]               dly,
    output onoff_pkg::seq_status_type    seq_status
);
    logic [3:0] req, req_reg;
    logic [7:0] cnt_reg;
    // Done only once a phase has stood dly cycles, never on a stale count
    assign req = {seq_power_up, seq_power_down, seq_imm_shdn, seq_bias_off};
    assign seq_status = (req == req_reg && cnt_reg >= dly) ? req : 4'h0;
    // Phase timer restarts whenever the request changes
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            req_reg <= 4'h0;
            cnt_reg <= 8'h00;
        end else begin
            req_reg <= req;
            cnt_reg <= (req != req_reg) ? 8'h00 : cnt_reg + {7'h00, cnt_reg != 8'hFF};
        end
    end
endmodule

// file: test/tb_top.sv
/* Self-checking bench for the on/off state controller.
 * Assumes the sequencer stand-in and the bound port checker. */
`timescale 1ns/10ps
module tb_top;
    logic ref_clk = 1'b0, arst_n = 1'b0, por_n = 1'b1, wake_request_n = 1'b1, wake_fall = 1'b0;
    logic manual_reset = 1'b0, soft_command_write = 1'b0, bias_low_power = 1'b1, flags_clear = 1'b0;
    logic irq_pending = 1'b0, irq_unmasked = 1'b0, irq_out_n, irq_out_oe_n, bias_enable, bias_lp, bus_enable;
    logic seq_power_up, seq_power_down, seq_imm_shdn, seq_bias_off;
    logic [1:0] wake_input_mode = 2'h0;
    logic [2:0] soft_command_field = 3'h0;
    logic [11:0] channel_enable_field = 12'h03E; // Channel 0 code 6, channel 1 code 7
    logic [3:0] channel_on;
    logic [7:0] dly = 8'h00;
    onoff_pkg::fault_type faults = 3'h0, event_record_flags;
    onoff_pkg::state_type state;
    onoff_pkg::seq_status_type seq_status;
    int n_fail = 0, samples_checked = 0, cycles = 0;
    always #25 ref_clk = ~ref_clk;
    onoff_ctrl onoff_ctrl_inst (.*);
    seq_model seq_model_inst (.*);
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("fails=%0d checks=%0d", n_fail, samples_checked);
        if (n_fail == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bounded wait so a stuck state shows as a mismatch, not a hang
    task automatic ws(input onoff_pkg::state_type s);
        for (int i = 0; i < 80 && state !== s; i++) @(negedge ref_clk);
        chk(state, s);
    endtask
    // One-cycle strobes: k 0 command write, 1 wake edge, 2 manual reset
    task automatic strobe(input int k, input logic [2:0] c);
        @(posedge ref_clk);
        soft_command_field <= c;
        soft_command_write <= (k == 0);
        wake_fall <= (k == 1);
        manual_reset <= (k == 2);
        @(posedge ref_clk);
        {soft_command_write, wake_fall, manual_reset} <= 3'h0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_wake;
        ws(onoff_pkg::ST_SHUTDOWN);
        chk({bias_enable, bus_enable}, 2'h0);
        strobe(1, 3'h0);
        ws(onoff_pkg::ST_POWER_UP);
        ws(onoff_pkg::ST_RES_ON);
        chk({channel_on, bias_enable, bus_enable}, 6'h3F);
    endtask
    task automatic t_irq;
        @(posedge ref_clk) irq_pending <= 1'b1;
        repeat (3) @(negedge ref_clk);
        chk(irq_out_oe_n, 1'b1);
        @(posedge ref_clk) irq_unmasked <= 1'b1;
        repeat (2) @(negedge ref_clk);
        chk({irq_out_oe_n, irq_out_n}, 2'h0);
        @(posedge ref_clk) irq_pending <= 1'b0;
        repeat (2) @(negedge ref_clk);
        chk(irq_out_oe_n, 1'b1);
    endtask
    // Each standby exit cause in turn, with a slow sequencer
    task automatic t_standby;
        dly <= 8'h05;
        for (int k = 0; k < 3; k++) begin
            @(posedge ref_clk) bias_low_power <= (k != 1); // Second pass runs standby at full bias
            strobe(0, onoff_pkg::CMD_STANDBY);
            ws(onoff_pkg::ST_POWER_DN);
            ws(onoff_pkg::ST_STANDBY);
            chk({channel_on, bias_enable, bus_enable, bias_lp}, {4'h3, 2'h3, k != 1});
            strobe(k, (k == 0) ? onoff_pkg::CMD_EXIT_STBY : 3'h0);
            ws(onoff_pkg::ST_WAKE);
            ws(onoff_pkg::ST_RES_ON);
        end
        // A standing standby code without a write must not act again
        @(posedge ref_clk) soft_command_field <= onoff_pkg::CMD_STANDBY;
        repeat (6) @(negedge ref_clk);
        chk(state, onoff_pkg::ST_RES_ON);
    endtask
    // Cold reset, power off, manual reset, each back to shutdown
    task automatic t_power_down;
        dly <= 8'h00;
        for (int k = 0; k < 3; k++) begin
            strobe((k == 2) ? 2 : 0, (k == 0) ? onoff_pkg::CMD_COLD_RESET : onoff_pkg::CMD_POWER_OFF);
            ws(onoff_pkg::ST_POWER_DN);
            ws(onoff_pkg::ST_BIAS_OFF);
            ws(onoff_pkg::ST_SHUTDOWN);
            if (k != 0) strobe(1, 3'h0);
            ws(onoff_pkg::ST_RES_ON);
        end
    endtask
    task automatic t_fault;
        @(posedge ref_clk) faults.thermal <= 1'b1;
        ws(onoff_pkg::ST_IMM_SHDN);
        ws(onoff_pkg::ST_SHUTDOWN);
        strobe(1, 3'h0);
        ws(onoff_pkg::ST_WAKE);
        @(negedge ref_clk);
        chk({state, event_record_flags}, {onoff_pkg::ST_SHUTDOWN, 3'h1});
        @(posedge ref_clk) faults <= 3'h0;
        strobe(3, 3'h0);
        @(posedge ref_clk) flags_clear <= 1'b1;
        @(posedge ref_clk) flags_clear <= 1'b0;
        @(negedge ref_clk);
        chk(event_record_flags, 3'h0);
    endtask
    task automatic t_modes;
        @(posedge ref_clk) wake_input_mode <= onoff_pkg::MODE_LOGIC;
        wake_request_n <= 1'b0;
        ws(onoff_pkg::ST_RES_ON);
        @(posedge ref_clk) wake_request_n <= 1'b1;
        ws(onoff_pkg::ST_POWER_DN);
        ws(onoff_pkg::ST_SHUTDOWN);
        @(posedge ref_clk) wake_input_mode <= onoff_pkg::MODE_SLIDE;
        strobe(1, 3'h0);
        ws(onoff_pkg::ST_RES_ON);
    endtask
    // Supply drop from resource-on, then recovery into shutdown
    task automatic t_por;
        @(posedge ref_clk) por_n <= 1'b0;
        repeat (2) @(negedge ref_clk);
        chk({state, channel_on, bias_enable}, {onoff_pkg::ST_RESET, 4'h0, 1'b0});
        @(posedge ref_clk) por_n <= 1'b1;
        ws(onoff_pkg::ST_SHUTDOWN);
        chk({bias_enable, bus_enable}, 2'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Hang guard well above the few hundred cycles the run needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_wake();
        t_irq();
        t_standby();
        t_power_down();
        t_fault();
        t_modes();
        t_por();
        report_and_stop();
    end
endmodule
